// *** verilog/ast_pkg.sv ***
// Purpose: Shared constants and types of the async serial transmitter.
// Assumes: One clock cycle stands for one instruction cycle.
// Notes: Register offsets are word indexes on the plain register port.
package ast_pkg;
    // Register port address width and data width.
    localparam int AW = 4;
    localparam int DW = 8;
    // Register offsets.
    localparam logic [3:0] OFS_TRANSMIT_CONTROL_STATUS = 4'h0;
    localparam logic [3:0] OFS_TXBUF = 4'h1;
    localparam logic [3:0] OFS_BAUD = 4'h2;
    localparam logic [3:0] OFS_FLAGS = 4'h3;
    localparam logic [3:0] OFS_ENAB = 4'h4;
    localparam logic [3:0] OFS_PRIO = 4'h5;
    localparam logic [3:0] OFS_ISTAT = 4'h6;
    localparam logic [3:0] OFS_IEN = 4'h7;
    localparam logic [3:0] OFS_ICLR = 4'h8;
    // Fields of the transmit control and status register.
    localparam int B_CLOCK_SOURCE_SELECT = 7;
    localparam int B_TX9 = 6;
    localparam int B_TRANSMIT_ENABLE = 5;
    localparam int B_SYNC = 4;
    localparam int B_BAUD_HIGH_SPEED_SELECT = 2;
    localparam int B_SHIFTER_EMPTY_STATUS = 1;
    localparam int B_NINTH_BIT_VALUE = 0;
    localparam logic [7:0] CTL_WMASK = 8'hf5;
    // Transmit buffer flag and enable position in the peripheral registers.
    localparam int B_TX_BUFFER_EMPTY_FLAG = 4;
    // Sticky event bits.
    localparam int EV_EMPTY = 0;
    localparam int EV_DONE = 1;
    localparam int NEV = 2;
    // Values after reset.
    localparam logic [7:0] TRANSMIT_CONTROL_STATUS_RST = 8'h02;
    localparam logic [7:0] PRIO_RST = 8'hff;
    localparam logic [7:0] ZERO_RST = 8'h00;
    // Baud ticks per bit, minus one, for x16 and x64.
    localparam logic [5:0] TERM_X16 = 6'h0f;
    localparam logic [5:0] TERM_X64 = 6'h3f;
    // Index of the last data bit for 8 and 9 bit frames.
    localparam logic [3:0] LAST_8 = 4'h7;
    localparam logic [3:0] LAST_9 = 4'h8;
    // Transmitter states.
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_START,
        ST_DATA,
        ST_STOP
    } ast_state_e;
endpackage

// *** verilog/ast_baud_gen.sv ***
// Purpose: Baud generator with an 8-bit divisor, one tick per rollover.
// Assumes: Runs only while the transmitter is active and awake.
// Notes: Tick rate is the clock divided by divisor plus one.
module ast_baud_gen #(
    parameter int WIDTH = 8
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic run_in,
    input wire logic [WIDTH-1:0] div_in,
    output logic tick_out
);
    import ast_pkg::*;

    logic [WIDTH-1:0] cnt_q;

    // Count down, reload on zero and pulse the tick.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cnt_q <= '0;
            tick_out <= 1'b0;
        end else if (!run_in) begin
            cnt_q <= div_in;
            tick_out <= 1'b0;
        end else if (cnt_q == '0) begin
            cnt_q <= div_in;
            tick_out <= 1'b1;
        end else begin
            cnt_q <= cnt_q - 1'b1;
            tick_out <= 1'b0;
        end
    end
endmodule

// *** verilog/ast_tx.sv ***
// Purpose: Asynchronous serial transmitter with its register file.
// Assumes: One clock cycle is one instruction cycle; inputs synchronous.
// Notes: The shift register has no path to the register port.
module ast_tx (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic [ast_pkg::AW-1:0] addr_in,
    input wire logic [ast_pkg::DW-1:0] wr_data_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    output logic [ast_pkg::DW-1:0] rd_data_out,
    input wire logic sleep_in,
    output logic tx_out,
    output logic irq_out
);
    import ast_pkg::*;

    logic [7:0] ctl_q;
    logic [7:0] hold_q;
    logic [7:0] baud_q;
    logic [7:0] enab_q;
    logic [7:0] prio_q;
    logic [NEV-1:0] istat_q;
    logic [NEV-1:0] ien_q;
    logic pend_q;
    logic full_q;
    logic transmit_enable_d1_q;
    ast_state_e st_q;
    logic [5:0] sub_q;
    logic [3:0] bit_q;
    logic [8:0] sh_q;
    logic n9_q;
    logic transmit_enable;
    logic sync_sel;
    logic halt;
    logic active;
    logic tick;
    logic bit_end;
    logic load;
    logic tx_buffer_empty_flag;
    logic shifter_empty_status;
    logic [5:0] term;
    logic [3:0] last;
    logic wr_hold;
    logic [NEV-1:0] ev;
    logic [NEV-1:0] clr;
    logic [7:0] ctl_rd;
    logic [7:0] flags_rd;
    logic [7:0] rd_mux;

    // Decoded control bits and activity terms.
    assign transmit_enable = ctl_q[B_TRANSMIT_ENABLE];
    assign sync_sel = ctl_q[B_SYNC];
    assign halt = !transmit_enable || sync_sel;
    assign active = !halt && !sleep_in;
    assign wr_hold = wr_en_in && (addr_in == OFS_TXBUF);
    assign term = ctl_q[B_BAUD_HIGH_SPEED_SELECT] ? TERM_X16 : TERM_X64;
    assign bit_end = tick && !sleep_in && (sub_q == term);
    assign last = n9_q ? LAST_9 : LAST_8;
    assign load = active && full_q && (st_q == ST_IDLE);
    assign tx_buffer_empty_flag = transmit_enable && !full_q;
    assign shifter_empty_status = (st_q == ST_IDLE);

    // Shared baud generator; the receive side would take the same tick.
    ast_baud_gen #(
        .WIDTH(8)
    ) u_baud (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .run_in(active),
        .div_in(baud_q),
        .tick_out(tick)
    );

    // Control register; the status bit and the gap at bit 3 are not stored.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ctl_q <= TRANSMIT_CONTROL_STATUS_RST & CTL_WMASK;
        end else if (wr_en_in && addr_in == OFS_TRANSMIT_CONTROL_STATUS) begin
            ctl_q <= wr_data_in & CTL_WMASK;
        end
    end

    // Plain software registers.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            baud_q <= ZERO_RST;
            enab_q <= ZERO_RST;
            prio_q <= PRIO_RST;
            ien_q <= '0;
        end else if (wr_en_in) begin
            if (addr_in == OFS_BAUD) begin
                baud_q <= wr_data_in;
            end
            if (addr_in == OFS_ENAB) begin
                enab_q <= wr_data_in;
            end
            if (addr_in == OFS_PRIO) begin
                prio_q <= wr_data_in;
            end
            if (addr_in == OFS_IEN) begin
                ien_q <= wr_data_in[NEV-1:0];
            end
        end
    end

    // Holding buffer data and the one-cycle delay of its full mark.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            hold_q <= ZERO_RST;
            pend_q <= 1'b0;
        end else begin
            pend_q <= wr_hold;
            if (wr_hold) begin
                hold_q <= wr_data_in;
            end
        end
    end

    // Buffer full mark; a new write wins over a transfer in the same cycle.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            full_q <= 1'b0;
            transmit_enable_d1_q <= 1'b0;
        end else begin
            transmit_enable_d1_q <= transmit_enable;
            if (halt || (transmit_enable && !transmit_enable_d1_q)) begin
                full_q <= 1'b0;
            end else if (pend_q) begin
                full_q <= 1'b1;
            end else if (load) begin
                full_q <= 1'b0;
            end
        end
    end

    // Frame sequencer; sleep freezes it, disable or sync mode aborts it.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st_q <= ST_IDLE;
            sub_q <= '0;
            bit_q <= '0;
            sh_q <= '0;
            n9_q <= 1'b0;
        end else if (halt) begin
            st_q <= ST_IDLE;
            sub_q <= '0;
            bit_q <= '0;
        end else if (!sleep_in) begin
            if (st_q != ST_IDLE && tick) begin
                sub_q <= bit_end ? 6'h00 : sub_q + 6'h01;
            end
            case (st_q)
                ST_IDLE: begin
                    if (load) begin
                        // Ninth bit sits above the byte.
                        sh_q <= {ctl_q[B_NINTH_BIT_VALUE], hold_q};
                        n9_q <= ctl_q[B_TX9];
                        sub_q <= '0;
                        bit_q <= '0;
                        st_q <= ST_START;
                    end
                end
                ST_START: begin
                    if (bit_end) begin
                        st_q <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (bit_end) begin
                        sh_q <= {1'b0, sh_q[8:1]};
                        bit_q <= bit_q + 4'h1;
                        if (bit_q == last) begin
                            st_q <= ST_STOP;
                        end
                    end
                end
                ST_STOP: begin
                    if (bit_end) begin
                        st_q <= ST_IDLE;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Line driver: low for start, data bit, otherwise high mark.
    // Disable forces the mark at once, so a sleep that follows cannot
    // leave a stale data level parked on the line.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tx_out <= 1'b1;
        end else if (halt) begin
            tx_out <= 1'b1;
        end else if (!sleep_in) begin
            case (st_q)
                ST_START: tx_out <= 1'b0;
                ST_DATA: tx_out <= sh_q[0];
                default: tx_out <= 1'b1;
            endcase
        end
    end

    // Sticky events; a new event wins over a clear in the same cycle.
    assign ev[EV_EMPTY] = load;
    assign ev[EV_DONE] = (st_q == ST_STOP) && bit_end && !halt;
    assign clr = (wr_en_in && addr_in == OFS_ICLR) ?
        wr_data_in[NEV-1:0] : '0;
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            istat_q <= '0;
        end else begin
            istat_q <= (istat_q & ~clr) | ev;
        end
    end

    // Interrupt: enabled sticky events or the enabled buffer empty flag.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= (|(istat_q & ien_q)) || (tx_buffer_empty_flag && enab_q[B_TX_BUFFER_EMPTY_FLAG]);
        end
    end

    // Read views; the flag register is read only and holds the empty flag.
    always_comb begin
        ctl_rd = ctl_q;
        ctl_rd[B_SHIFTER_EMPTY_STATUS] = shifter_empty_status;
        flags_rd = ZERO_RST;
        flags_rd[B_TX_BUFFER_EMPTY_FLAG] = tx_buffer_empty_flag;
        case (addr_in)
            OFS_TRANSMIT_CONTROL_STATUS: rd_mux = ctl_rd;
            OFS_TXBUF: rd_mux = hold_q;
            OFS_BAUD: rd_mux = baud_q;
            OFS_FLAGS: rd_mux = flags_rd;
            OFS_ENAB: rd_mux = enab_q;
            OFS_PRIO: rd_mux = prio_q;
            OFS_ISTAT: rd_mux = {{(8-NEV){1'b0}}, istat_q};
            OFS_IEN: rd_mux = {{(8-NEV){1'b0}}, ien_q};
            default: rd_mux = ZERO_RST;
        endcase
    end

    // Read data stands for one cycle after the strobe, zero otherwise.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rd_data_out <= ZERO_RST;
        end else begin
            rd_data_out <= rd_en_in ? rd_mux : ZERO_RST;
        end
    end

    // A buffer write keeps the flag valid only from the second cycle on.
    property p_flag_delay;
        @(posedge clk_in) disable iff (!reset_n_in)
        (wr_hold && transmit_enable && !sync_sel)
            |-> ##2 (!tx_buffer_empty_flag || halt);
    endproperty
    a_flag_delay: assert property (p_flag_delay)
        else $error("empty flag not cleared two cycles after write");

    // A transfer empties the buffer and raises the flag next cycle.
    property p_load_flag;
        @(posedge clk_in) disable iff (!reset_n_in)
        (load && !pend_q && !halt) |=> (tx_buffer_empty_flag || halt);
    endproperty
    a_load_flag: assert property (p_load_flag)
        else $error("empty flag not set after transfer");

    // A pending byte moves to the shifter right after the stop bit.
    property p_load_idle;
        @(posedge clk_in) disable iff (!reset_n_in)
        (st_q == ST_STOP && bit_end && full_q && !halt)
            |=> (load || sleep_in || halt);
    endproperty
    a_load_idle: assert property (p_load_idle)
        else $error("pending byte not moved after stop bit");

    // A load leaves the shifter busy and sends a low start bit.
    property p_start_low;
        @(posedge clk_in) disable iff (!reset_n_in)
        (load && ctl_q[B_TRANSMIT_ENABLE]) |=> !shifter_empty_status
            ##1 (!tx_out || $past(halt) || $past(sleep_in));
    endproperty
    a_start_low: assert property (p_start_low)
        else $error("start bit missing after load");

    // Sleep freezes the sequencer state and its baud tick count.
    property p_sleep;
        @(posedge clk_in) disable iff (!reset_n_in)
        (sleep_in && !halt) |=> ($stable(st_q) && $stable(sub_q));
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("transmitter moved during sleep");

    // Sync mode or disable returns to idle and the line to high.
    property p_halt_idle;
        @(posedge clk_in) disable iff (!reset_n_in)
        halt |=> (st_q == ST_IDLE) && tx_out;
    endproperty
    a_halt_idle: assert property (p_halt_idle)
        else $error("not idle while disabled");

    // At x16 speed a bit ends on its sixteenth baud tick.
    property p_sub_bound;
        @(posedge clk_in) disable iff (!reset_n_in)
        (st_q != ST_IDLE && ctl_q[B_BAUD_HIGH_SPEED_SELECT] && tick && !sleep_in
            && sub_q == TERM_X16) |=> (sub_q == 6'h00);
    endproperty
    a_sub_bound: assert property (p_sub_bound)
        else $error("x16 bit count exceeded");

    // Enabling the transmitter sets the empty flag next cycle.
    property p_enable_flag;
        @(posedge clk_in) disable iff (!reset_n_in)
        ($rose(transmit_enable) && !sync_sel) |=> (tx_buffer_empty_flag || !transmit_enable);
    endproperty
    a_enable_flag: assert property (p_enable_flag)
        else $error("enable did not set empty flag");

    // Data bits leave low bit first: each data bit sends the old bit one.
    property p_lsb_first;
        @(posedge clk_in) disable iff (!reset_n_in)
        (st_q == ST_DATA && bit_end && bit_q != last && !halt)
            |=> (sh_q[0] == $past(sh_q[1]));
    endproperty
    a_lsb_first: assert property (p_lsb_first)
        else $error("shift order wrong");
endmodule

// *** tb/ast_line_rx.sv ***
// Purpose: Far-end receiver model that decodes frames seen on the line.
// Assumes: The bench sets the bit length in clocks and the nine-bit mode.
// Notes: Only frames with a low start and a high stop are counted.
module ast_line_rx (
    input wire logic clk_in,
    input wire logic line_in,
    input wire logic [15:0] bit_clks_in,
    input wire logic nine_in,
    output logic [8:0] data_out,
    output logic [7:0] frames_out,
    output logic [15:0] low_len_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] run_q = 16'h0000;
    logic [15:0] len_q = 16'h0000;
    logic [8:0] sh;
    logic ok;
    // Measures the last low run so the bench can judge the bit time.
    assign low_len_out = len_q;
    always @(posedge clk_in) begin
        if (line_in === 1'b0) begin
            run_q <= run_q + 16'h0001;
        end else begin
            if (run_q != 16'h0000) begin
                len_q <= run_q;
            end
            run_q <= 16'h0000;
        end
    end
    // Samples every bit in its middle, starting from the falling edge.
    initial begin
        data_out = 9'h000;
        frames_out = 8'h00;
        forever begin
            @(negedge line_in);
            repeat (bit_clks_in / 2) @(posedge clk_in);
            ok = (line_in === 1'b0);
            sh = 9'h000;
            for (int i = 0; i < (nine_in ? 9 : 8); i++) begin
                repeat (bit_clks_in) @(posedge clk_in);
                sh[i] = line_in;
            end
            repeat (bit_clks_in) @(posedge clk_in);
            if (ok && line_in === 1'b1) begin
                data_out = sh;
                frames_out = frames_out + 8'h01;
            end
        end
    end
endmodule

// *** tb/async_serial_transmitter_tb.sv ***
// Purpose: Self-checking bench for the async serial transmitter.
// Assumes: Register reads answer in the cycle after the strobe.
// Notes: Frames are decoded by the far-end model and compared here.
module async_serial_transmitter_tb;
    import ast_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in, reset_n_in, wr_en_in, rd_en_in, sleep_in, tx_out, irq_out;
    logic [AW-1:0] addr_in;
    logic [DW-1:0] wr_data_in, rd_data_out, r;
    logic [15:0] bit_clks, low_len;
    logic nine;
    logic [8:0] rx_data;
    logic [7:0] frames;
    int mismatches, n_tests;

    // Device under test and the far-end receiver on its line.
    ast_tx dut_u (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in),
        .rd_en_in(rd_en_in), .rd_data_out(rd_data_out),
        .sleep_in(sleep_in), .tx_out(tx_out), .irq_out(irq_out));
    ast_line_rx line_u (.clk_in(clk_in), .line_in(tx_out),
        .bit_clks_in(bit_clks), .nine_in(nine), .data_out(rx_data),
        .frames_out(frames), .low_len_out(low_len));

    // Free-running 25 MHz clock.
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Counts and reports one mismatch.
    task automatic fail(input string m);
        mismatches++;
        $display("unexpected at %0t: %s", $time, m);
    endtask

    // Compares a register or pin value.
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp,
                           input string m);
        n_tests++;
        if (got !== exp) fail($sformatf("%s got %h exp %h", m, got, exp));
    endtask

    // Compares a frame decoded by the far end.
    task automatic chk_rx(input logic [8:0] exp);
        n_tests++;
        if (rx_data !== exp) fail($sformatf("frame %h exp %h", rx_data, exp));
    endtask

    // Checks that the last low run lies in a window of clocks.
    task automatic chk_len(input int lo, input int hi);
        n_tests++;
        if ((low_len >= lo && low_len <= hi) !== 1'b1) begin
            fail($sformatf("low run %0d", low_len));
        end
    endtask

    // One-cycle write strobe.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wr_data_in <= d;
        wr_en_in <= 1'b1;
        @(posedge clk_in);
        wr_en_in <= 1'b0;
    endtask

    // One-cycle read strobe, data taken in the following cycle.
    task automatic rdchk(input logic [3:0] a, input logic [7:0] exp,
                         input string m);
        @(posedge clk_in);
        addr_in <= a;
        rd_en_in <= 1'b1;
        @(posedge clk_in);
        rd_en_in <= 1'b0;
        #1 chk_reg(rd_data_out, exp, m);
    endtask

    // Waits a bounded time for the next complete frame.
    task automatic wait_rx();
        logic [7:0] f0;
        f0 = frames;
        for (int i = 0; i < 5000 && frames === f0; i++) @(posedge clk_in);
        if (frames === f0) begin
            fail("no frame");
            print_verdict();
        end
    endtask

    // Waits a few cycles for the interrupt level, then compares it.
    task automatic wait_irq(input logic exp);
        for (int i = 0; i < 4 && irq_out !== exp; i++) begin
            @(posedge clk_in);
            #1;
        end
        chk_reg({7'h00, irq_out}, {7'h00, exp}, "irq");
    endtask

    // Main sequence.
    initial begin
        {wr_en_in, rd_en_in, sleep_in, reset_n_in, nine} = 5'h00;
        addr_in = 4'h0;
        wr_data_in = 8'h00;
        bit_clks = 16'h0010;
        repeat (8) @(posedge clk_in);
        reset_n_in <= 1'b1;
        #1 chk_reg({7'h00, tx_out}, 8'h01, "idle line");
        rdchk(OFS_TRANSMIT_CONTROL_STATUS, TRANSMIT_CONTROL_STATUS_RST, "ctl");
        rdchk(OFS_TXBUF, ZERO_RST, "buf");
        rdchk(OFS_BAUD, ZERO_RST, "baud");
        rdchk(OFS_FLAGS, ZERO_RST, "flags");
        rdchk(OFS_ENAB, ZERO_RST, "enab");
        rdchk(OFS_PRIO, PRIO_RST, "prio");
        rdchk(OFS_ISTAT, ZERO_RST, "istat");
        rdchk(4'hf, ZERO_RST, "unmapped");
        wr(OFS_TRANSMIT_CONTROL_STATUS, 8'h0a);
        rdchk(OFS_TRANSMIT_CONTROL_STATUS, 8'h02, "ro bits");
        wr(OFS_PRIO, 8'h5a);
        rdchk(OFS_PRIO, 8'h5a, "prio rw");
        $display("test reset done");
        wr(OFS_TRANSMIT_CONTROL_STATUS, 8'h24);
        rdchk(OFS_FLAGS, 8'h10, "flag on enable");
        rdchk(OFS_TRANSMIT_CONTROL_STATUS, 8'h26, "idle ctl");
        wr(OFS_FLAGS, 8'h00);
        rdchk(OFS_FLAGS, 8'h10, "flag kept");
        wr(OFS_ENAB, 8'h10);
        wait_irq(1'b1);
        wr(OFS_ENAB, 8'h00);
        wait_irq(1'b0);
        $display("test enable done");
        wr(OFS_TXBUF, 8'h00);
        repeat (4) @(posedge clk_in);
        rdchk(OFS_TRANSMIT_CONTROL_STATUS, 8'h24, "busy ctl");
        // Write while busy, then read the flag in the next two cycles.
        @(posedge clk_in);
        wr_en_in <= 1'b1;
        addr_in <= OFS_TXBUF;
        wr_data_in <= 8'h96;
        @(posedge clk_in);
        wr_en_in <= 1'b0;
        rd_en_in <= 1'b1;
        addr_in <= OFS_FLAGS;
        @(posedge clk_in);
        #1 r = rd_data_out;
        chk_reg(r, 8'h10, "flag c1");
        @(posedge clk_in);
        rd_en_in <= 1'b0;
        #1 chk_reg(rd_data_out, 8'h00, "flag c2");
        wait_rx();
        chk_rx(9'h000);
        chk_len(142, 144);
        wait_rx();
        chk_rx(9'h096);
        repeat (16) @(posedge clk_in);
        rdchk(OFS_TRANSMIT_CONTROL_STATUS, 8'h26, "shifter empty");
        rdchk(OFS_FLAGS, 8'h10, "flag after");
        rdchk(OFS_ISTAT, 8'h03, "events");
        wr(OFS_IEN, 8'h02);
        wait_irq(1'b1);
        wr(OFS_ICLR, 8'h03);
        rdchk(OFS_ISTAT, 8'h00, "cleared");
        wait_irq(1'b0);
        $display("test frames done");
        wr(OFS_TRANSMIT_CONTROL_STATUS, 8'h34);
        wr(OFS_TXBUF, 8'h55);
        repeat (100) @(posedge clk_in);
        #1 chk_reg({7'h00, tx_out}, 8'h01, "sync idle");
        rdchk(OFS_TRANSMIT_CONTROL_STATUS, 8'h36, "sync ctl");
        wr(OFS_TRANSMIT_CONTROL_STATUS, 8'h24);
        $display("test sync done");
        @(posedge clk_in);
        sleep_in <= 1'b1;
        wr(OFS_TXBUF, 8'hc3);
        repeat (100) @(posedge clk_in);
        #1 chk_reg({7'h00, tx_out}, 8'h01, "sleep idle");
        rdchk(OFS_TRANSMIT_CONTROL_STATUS, 8'h26, "sleep ctl");
        @(posedge clk_in);
        sleep_in <= 1'b0;
        wait_rx();
        chk_rx(9'h0c3);
        repeat (16) @(posedge clk_in);
        $display("test sleep done");
        wr(OFS_BAUD, 8'h01);
        bit_clks = 16'd128;
        nine = 1'b1;
        wr(OFS_TRANSMIT_CONTROL_STATUS, 8'h61);
        wr(OFS_TXBUF, 8'h00);
        wait_rx();
        chk_rx(9'h100);
        chk_len(1149, 1152);
        $display("test nine bit done");
        print_verdict();
    end
endmodule
